// [hdl/rxg_chan_eng.sv]
// Purpose: per-channel block sequencer for the receive DMA
// Assumes: FIFO and queue manager signals are on the same clock
// Notes: starvation answer is sampled in the same cycle the buffer request is high
`timescale 1ns/1ps
module rxg_chan_eng
  import rxg_pkg::*;
#(
  parameter int GAP = RETRY_GAP
) (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Configuration
  input wire logic en_i,
  input wire logic td_req_i,
  input wire logic [1:0] kind_i,
  input wire logic [1:0] qmgr_i,
  input wire logic [11:0] qnum_i,
  input wire logic err_mode_i,
  input wire logic [7:0] skip_i,
  input wire logic [1:0] pool_qmgr_i,
  input wire logic [11:0] pool_qnum_i,
  // FIFO block interface
  input wire logic blk_valid_i,
  input wire logic blk_sop_i,
  input wire logic blk_eop_i,
  input wire logic ovr_i,
  input wire logic [1:0] ovr_kind_i,
  input wire logic [1:0] ovr_qmgr_i,
  input wire logic [11:0] ovr_qnum_i,
  input wire logic starve_i,
  // Results
  output logic adv_o,
  output logic buf_req_o,
  output logic buf_first_o,
  output logic [1:0] pool_qmgr_o,
  output logic [11:0] pool_qnum_o,
  output logic [7:0] skip_o,
  output logic done_o,
  output logic [1:0] dest_qmgr_o,
  output logic [11:0] dest_qnum_o,
  output logic reclaim_o,
  output logic retry_o,
  output logic td_done_o,
  output logic busy_o
);
  typedef enum logic [1:0] {ST_IDLE, ST_ALLOC, ST_XFER, ST_DROP} rxg_state_t;
  rxg_state_t state_r, state_nxt;
  logic [1:0] kind_r;
  logic [4:0] gap_r;
  logic eop_r;
  wire start_w = en_i && blk_valid_i && !adv_o && gap_r == 5'h00 && !td_req_i;
  wire bad_kind_w = kind_r != KIND_HOST;
  wire err_w = starve_i || bad_kind_w;
  wire retry_w = err_w && !bad_kind_w && err_mode_i;
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (start_w) begin
          state_nxt = ST_ALLOC;
        end
      end
      ST_ALLOC: begin
        if (!err_w) begin
          state_nxt = ST_XFER;
        end else if (retry_w) begin
          state_nxt = ST_IDLE;
        end else begin
          state_nxt = eop_r ? ST_IDLE : ST_DROP;
        end
      end
      ST_XFER: state_nxt = ST_IDLE;
      ST_DROP: begin
        if (blk_valid_i && !adv_o && blk_eop_i) begin
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= ST_IDLE;
      kind_r <= 2'h0;
      gap_r <= 5'h00;
      eop_r <= 1'b0;
      adv_o <= 1'b0;
      buf_req_o <= 1'b0;
      buf_first_o <= 1'b0;
      pool_qmgr_o <= 2'h0;
      pool_qnum_o <= 12'h000;
      skip_o <= 8'h00;
      done_o <= 1'b0;
      dest_qmgr_o <= 2'h0;
      dest_qnum_o <= 12'h000;
      reclaim_o <= 1'b0;
      retry_o <= 1'b0;
      td_done_o <= 1'b0;
      busy_o <= 1'b0;
    end else if (ce_i) begin
      state_r <= state_nxt;
      busy_o <= state_nxt != ST_IDLE;
      adv_o <= 1'b0;
      buf_req_o <= 1'b0;
      done_o <= 1'b0;
      reclaim_o <= 1'b0;
      retry_o <= 1'b0;
      // Teardown completes only between blocks
      td_done_o <= state_r == ST_IDLE && td_req_i && !td_done_o;
      if (gap_r != 5'h00) begin
        gap_r <= gap_r - 5'h01;
      end
      if (state_r == ST_IDLE && start_w) begin
        buf_req_o <= 1'b1;
        buf_first_o <= blk_sop_i;
        eop_r <= blk_eop_i;
        pool_qmgr_o <= pool_qmgr_i;
        pool_qnum_o <= pool_qnum_i;
        skip_o <= blk_sop_i ? skip_i : 8'h00;
        if (blk_sop_i) begin
          // Block header wins over the programmed defaults
          kind_r <= ovr_i ? ovr_kind_i : kind_i;
          dest_qmgr_o <= ovr_i ? ovr_qmgr_i : qmgr_i;
          dest_qnum_o <= ovr_i ? ovr_qnum_i : qnum_i;
        end
      end
      if (state_r == ST_ALLOC && err_w) begin
        // Policy bit matters only here
        if (retry_w) begin
          retry_o <= 1'b1;
          gap_r <= 5'(GAP);
        end else begin
          reclaim_o <= 1'b1;
          adv_o <= 1'b1;
        end
      end
      if (state_r == ST_XFER) begin
        adv_o <= 1'b1;
        done_o <= eop_r;
      end
      if (state_r == ST_DROP && blk_valid_i && !adv_o) begin
        adv_o <= 1'b1;
      end
    end
  end

  skip_sop_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && state_r == ST_IDLE && start_w && blk_sop_i |=> skip_o == $past(skip_i))
    else $error("first buffer skip not applied");
  ovr_dest_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && state_r == ST_IDLE && start_w && blk_sop_i && ovr_i |=> dest_qnum_o == $past(ovr_qnum_i))
    else $error("override queue not taken");
  drop_reclaim_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && state_r == ST_ALLOC && starve_i && !err_mode_i |=> reclaim_o && adv_o && !done_o)
    else $error("starved packet not dropped");
  retry_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && state_r == ST_ALLOC && retry_w |=> retry_o && !adv_o ##1 !adv_o && !buf_req_o)
    else $error("retry advanced the FIFO");
  bad_kind_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && state_r == ST_ALLOC && bad_kind_w |=> !done_o ##1 !done_o)
    else $error("reserved descriptor kind completed");
  en_gate_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !en_i |=> !buf_req_o)
    else $error("disabled channel requested a buffer");
  pool_first_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    ce_i && state_r == ST_IDLE && start_w |=> buf_req_o && pool_qnum_o == $past(pool_qnum_i))
    else $error("first buffer pool wrong");
  retry_c: cover property (@(posedge clk_i) disable iff (!rst_n_i) retry_o);
  reclaim_c: cover property (@(posedge clk_i) disable iff (!rst_n_i) reclaim_o);
  done_c: cover property (@(posedge clk_i) disable iff (!rst_n_i) done_o && skip_o != 8'h00);
endmodule

// [hdl/rxg_pkg.sv]
// Purpose: shared constants for the receive channel configuration block
// Assumes: 32-bit Avalon-MM data, 16-bit registers in the low lanes
// Notes: byte address = channel * 16 + register * 4
package rxg_pkg;
  localparam int NUM_CH = 4;
  localparam int ADDR_W = 7;
  // Address decode fields
  localparam int CH_LSB = 4;
  localparam int REG_LSB = 2;
  localparam int MAP_BIT = 6;
  localparam logic [1:0] REG_QUEUE_CFG = 2'h0;
  localparam logic [1:0] REG_CTRL_CFG = 2'h1;
  localparam logic [1:0] REG_POOL_CFG = 2'h2;
  localparam logic [1:0] REG_STATUS = 2'h3;
  // Queue configuration register fields
  localparam int KIND_LSB = 14;
  localparam int QMGR_LSB = 12;
  localparam int QNUM_LSB = 0;
  localparam logic [1:0] KIND_HOST = 2'h1;
  // Control configuration register fields
  localparam int EN_BIT = 15;
  localparam int TD_BIT = 14;
  localparam int ERR_BIT = 8;
  localparam int SKIP_LSB = 0;
  localparam logic [15:0] QUEUE_CFG_RST = 16'h0000;
  localparam logic [15:0] POOL_CFG_MASK = 16'h3FFF;
  // Idle cycles before a starved block is tried again
  localparam int RETRY_GAP = 16;
endpackage

// [hdl/rxg_rst_sync.sv]
// Purpose: release of the asynchronous reset in step with the clock
// Assumes: reset asserts at any time, releases after two edges
// Notes: input stage flops take constants only
`timescale 1ns/1ps
module rxg_rst_sync (
  // Clock and raw reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Synchronised reset
  output logic rst_n_o
);
  logic meta_r;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta_r <= 1'b0;
      rst_n_o <= 1'b0;
    end else begin
      meta_r <= 1'b1;
      rst_n_o <= meta_r;
    end
  end
endmodule

// [hdl/rxg_top.sv]
// Purpose: receive channel global configuration and control, four channels
// Assumes: one clock; FIFO and queue manager signals share it
// Notes: Avalon-MM slave answers every access in two cycles
`timescale 1ns/1ps
module rxg_top
  import rxg_pkg::*;
#(
  parameter int CH = NUM_CH,
  parameter int GAP = RETRY_GAP
) (
  // Clock, reset, enable
  input wire logic CLK_SYS_I,
  input wire logic ARST_N_I,
  input wire logic CE_I,
  // Avalon-MM slave
  input wire logic [ADDR_W-1:0] ADDRESS_I,
  input wire logic READ_I,
  input wire logic WRITE_I,
  input wire logic [31:0] WRITEDATA_I,
  input wire logic [3:0] BYTEENABLE_I,
  output logic [31:0] READDATA_O,
  output logic WAITREQUEST_O,
  // FIFO block interface, one lane per channel
  input wire logic [CH-1:0] BLK_VALID_I,
  input wire logic [CH-1:0] BLK_SOP_I,
  input wire logic [CH-1:0] BLK_EOP_I,
  input wire logic [CH-1:0] OVR_I,
  input wire logic [2*CH-1:0] OVR_KIND_I,
  input wire logic [2*CH-1:0] OVR_QMGR_I,
  input wire logic [12*CH-1:0] OVR_QNUM_I,
  input wire logic [CH-1:0] STARVE_I,
  // Channel results
  output logic [CH-1:0] ADV_O,
  output logic [CH-1:0] BUF_REQ_O,
  output logic [CH-1:0] BUF_FIRST_O,
  output logic [2*CH-1:0] POOL_QMGR_O,
  output logic [12*CH-1:0] POOL_QNUM_O,
  output logic [8*CH-1:0] SKIP_O,
  output logic [CH-1:0] DONE_O,
  output logic [2*CH-1:0] DEST_QMGR_O,
  output logic [12*CH-1:0] DEST_QNUM_O,
  output logic [CH-1:0] RECLAIM_O,
  output logic [CH-1:0] RETRY_O
);
  logic rst_n;
  logic wait_r;
  // Per-channel register storage, indexed by channel
  logic [15:0] queue_cfg_r [CH];
  logic [15:0] pool_cfg_r [CH];
  logic [CH-1:0] en_r;
  logic [CH-1:0] td_req_r;
  logic [CH-1:0] td_flag_r;
  logic [CH-1:0] err_mode_r;
  logic [7:0] skip_r [CH];
  logic [CH-1:0] td_done;
  logic [CH-1:0] busy;

  rxg_rst_sync u_rst (
    .clk_i(CLK_SYS_I),
    .arst_n_i(ARST_N_I),
    .rst_n_o(rst_n)
  );

  // Address decode
  wire req_w = READ_I || WRITE_I;
  wire in_map_w = !ADDRESS_I[MAP_BIT];
  wire [1:0] ch_w = ADDRESS_I[CH_LSB+:2];
  wire [1:0] reg_w = ADDRESS_I[REG_LSB+:2];
  wire ch_ok_w = 32'(ch_w) < CH;
  wire hit_w = in_map_w && ch_ok_w;
  // Write lands on the edge where waitrequest is sampled low
  wire wr_w = WRITE_I && !wait_r && hit_w;
  wire [15:0] be_mask_w = {{8{BYTEENABLE_I[1]}}, {8{BYTEENABLE_I[0]}}};
  wire [15:0] ctrl_rd_w = {en_r[ch_w], td_flag_r[ch_w], 5'h00, err_mode_r[ch_w], skip_r[ch_w]};
  wire [15:0] status_rd_w = {15'h0000, busy[ch_w]};
  wire [15:0] rd_mux_w = !hit_w ? 16'h0000 :
    reg_w == REG_QUEUE_CFG ? queue_cfg_r[ch_w] :
    reg_w == REG_CTRL_CFG ? ctrl_rd_w :
    reg_w == REG_POOL_CFG ? pool_cfg_r[ch_w] : status_rd_w;
  wire [15:0] wdata_w = WRITEDATA_I[15:0];

  // Two-cycle answer: waitrequest drops for one cycle per access
  always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
    if (!rst_n) begin
      wait_r <= 1'b1;
      READDATA_O <= 32'h00000000;
    end else if (CE_I) begin
      wait_r <= !(req_w && wait_r);
      if (READ_I && wait_r) begin
        READDATA_O <= {16'h0000, rd_mux_w};
      end
    end
  end
  assign WAITREQUEST_O = wait_r;

  genvar g;
  generate
    for (g = 0; g < CH; g++) begin : g_ch
      // One set of three writable registers per channel
      wire sel_w = wr_w && 32'(ch_w) == g;
      wire q_wr_w = sel_w && reg_w == REG_QUEUE_CFG;
      wire c_wr_w = sel_w && reg_w == REG_CTRL_CFG;
      wire p_wr_w = sel_w && reg_w == REG_POOL_CFG;
      wire td_wr_w = c_wr_w && BYTEENABLE_I[1];
      wire en_wr_w = c_wr_w && BYTEENABLE_I[1];

      always_ff @(posedge CLK_SYS_I or negedge rst_n) begin
        if (!rst_n) begin
          queue_cfg_r[g] <= QUEUE_CFG_RST;
          pool_cfg_r[g] <= 16'h0000;
          en_r[g] <= 1'b0;
          td_req_r[g] <= 1'b0;
          td_flag_r[g] <= 1'b0;
          err_mode_r[g] <= 1'b0;
          skip_r[g] <= 8'h00;
        end else if (CE_I) begin
          if (q_wr_w) begin
            queue_cfg_r[g] <= (queue_cfg_r[g] & ~be_mask_w) | (wdata_w & be_mask_w);
          end
          if (p_wr_w) begin
            pool_cfg_r[g] <= ((pool_cfg_r[g] & ~be_mask_w) | (wdata_w & be_mask_w)) & POOL_CFG_MASK;
          end
          if (c_wr_w && BYTEENABLE_I[0]) begin
            skip_r[g] <= wdata_w[SKIP_LSB+:8];
          end
          if (c_wr_w && BYTEENABLE_I[1]) begin
            err_mode_r[g] <= wdata_w[ERR_BIT];
          end
          // Hardware clear of enable beats a same-cycle software write
          if (td_done[g]) begin
            en_r[g] <= 1'b0;
          end else if (en_wr_w) begin
            en_r[g] <= wdata_w[EN_BIT];
          end
          // Writing one while enabled asks for teardown
          if (td_done[g]) begin
            td_req_r[g] <= 1'b0;
          end else if (td_wr_w && wdata_w[TD_BIT] && en_r[g]) begin
            td_req_r[g] <= 1'b1;
          end
          // Completion set wins over a software clear
          if (td_done[g]) begin
            td_flag_r[g] <= 1'b1;
          end else if (td_wr_w && !wdata_w[TD_BIT]) begin
            td_flag_r[g] <= 1'b0;
          end
        end
      end

      rxg_chan_eng #(
        .GAP(GAP)
      ) u_eng (
        .clk_i(CLK_SYS_I),
        .rst_n_i(rst_n),
        .ce_i(CE_I),
        .en_i(en_r[g]),
        .td_req_i(td_req_r[g]),
        .kind_i(queue_cfg_r[g][KIND_LSB+:2]),
        .qmgr_i(queue_cfg_r[g][QMGR_LSB+:2]),
        .qnum_i(queue_cfg_r[g][QNUM_LSB+:12]),
        .err_mode_i(err_mode_r[g]),
        .skip_i(skip_r[g]),
        .pool_qmgr_i(pool_cfg_r[g][QMGR_LSB+:2]),
        .pool_qnum_i(pool_cfg_r[g][QNUM_LSB+:12]),
        .blk_valid_i(BLK_VALID_I[g]),
        .blk_sop_i(BLK_SOP_I[g]),
        .blk_eop_i(BLK_EOP_I[g]),
        .ovr_i(OVR_I[g]),
        .ovr_kind_i(OVR_KIND_I[2*g+:2]),
        .ovr_qmgr_i(OVR_QMGR_I[2*g+:2]),
        .ovr_qnum_i(OVR_QNUM_I[12*g+:12]),
        .starve_i(STARVE_I[g]),
        .adv_o(ADV_O[g]),
        .buf_req_o(BUF_REQ_O[g]),
        .buf_first_o(BUF_FIRST_O[g]),
        .pool_qmgr_o(POOL_QMGR_O[2*g+:2]),
        .pool_qnum_o(POOL_QNUM_O[12*g+:12]),
        .skip_o(SKIP_O[8*g+:8]),
        .done_o(DONE_O[g]),
        .dest_qmgr_o(DEST_QMGR_O[2*g+:2]),
        .dest_qnum_o(DEST_QNUM_O[12*g+:12]),
        .reclaim_o(RECLAIM_O[g]),
        .retry_o(RETRY_O[g]),
        .td_done_o(td_done[g]),
        .busy_o(busy[g])
      );

      td_clear_a: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
        CE_I && td_done[g] |=> !en_r[g] && td_flag_r[g] && !td_req_r[g])
        else $error("teardown did not clear enable");
      td_flag_a: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
        $rose(td_flag_r[g]) |-> $past(td_done[g]))
        else $error("completion flag set without teardown");
      td_c: cover property (@(posedge CLK_SYS_I) disable iff (!rst_n) td_done[g]);
    end
  endgenerate

  ack_bound_a: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
    CE_I && req_w && WAITREQUEST_O |=> !WAITREQUEST_O ##1 WAITREQUEST_O)
    else $error("bus answer not in two cycles");
  rsvd_zero_a: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
    READ_I && !WAITREQUEST_O && $past(reg_w) == REG_CTRL_CFG |-> READDATA_O[13:9] == 5'h00)
    else $error("reserved control bits not zero");
  unmapped_a: assert property (@(posedge CLK_SYS_I) disable iff (!rst_n)
    CE_I && READ_I && WAITREQUEST_O && !hit_w |=> READDATA_O == 32'h00000000)
    else $error("unmapped read not zero");
endmodule

// [verif/rxg_far_model.sv]
// Purpose: far-side FIFO and queue manager stand-in
// Assumes: one block popped per adv pulse
// Notes: starvation line toggles while nobody samples it
`timescale 1ns/1ps
module rxg_far_model #(
  parameter int CH = 4
) (
  // Clock and scenario control
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [CH-1:0] load_i,
  input wire logic [3:0] len_i,
  input wire logic [CH-1:0] starve_cfg_i,
  input wire logic [CH-1:0] ovr_cfg_i,
  // Block side
  input wire logic [CH-1:0] adv_i,
  input wire logic [CH-1:0] buf_req_i,
  output logic [CH-1:0] valid_o,
  output logic [CH-1:0] sop_o,
  output logic [CH-1:0] eop_o,
  output logic [CH-1:0] ovr_o,
  output logic [CH-1:0] starve_o,
  output logic [2*CH-1:0] kind_o,
  output logic [2*CH-1:0] qmgr_o,
  output logic [12*CH-1:0] qnum_o
);
  logic [3:0] left_r [CH];
  logic [3:0] total_r [CH];
  logic tog_r;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tog_r <= 1'b0;
      for (int g = 0; g < CH; g++) begin
        left_r[g] <= 4'h0;
        total_r[g] <= 4'h0;
      end
    end else begin
      tog_r <= ~tog_r;
      for (int g = 0; g < CH; g++) begin
        if (load_i[g]) begin
          left_r[g] <= len_i;
          total_r[g] <= len_i;
        end else if (adv_i[g] && left_r[g] != 4'h0) begin
          left_r[g] <= left_r[g] - 4'h1;
        end
      end
    end
  end
  for (genvar g = 0; g < CH; g++) begin : g_lane
    assign valid_o[g] = left_r[g] != 4'h0;
    assign sop_o[g] = valid_o[g] && left_r[g] == total_r[g];
    assign eop_o[g] = left_r[g] == 4'h1;
    // Header override fields
    assign ovr_o[g] = ovr_cfg_i[g];
    assign kind_o[2*g +: 2] = 2'h1;
    assign qmgr_o[2*g +: 2] = 2'(3 - g);
    assign qnum_o[12*g +: 12] = 12'hA00 + 12'(g);
    // Answer stands while the request pulse does, the cycle the engine samples it
    assign starve_o[g] = buf_req_i[g] ? starve_cfg_i[g] : tog_r;
  end
endmodule

// [verif/tb_top.sv]
// Purpose: self-checking bench for the receive channel configuration block
// Assumes: Avalon-MM answer time taken from waitrequest only
// Notes: retry gap shortened to 4 cycles
`timescale 1ns/1ps
module tb_top;
  import rxg_pkg::*;
  logic clk = 1'b0, arst_n = 1'b0, rd = 1'b0, wr = 1'b0;
  logic [6:0] addr = 7'h00;
  logic [31:0] wd = 32'h0, rdata, q;
  logic [3:0] be = 4'h0, len = 4'h0;
  logic [3:0] load = 4'h0, stv = 4'h0, ovr = 4'h0;
  logic waitreq;
  logic [3:0] valid, sop, eop, ovr_f, starve, adv, breq, bfirst, done, recl, retry;
  logic [7:0] kind, qmgr, pqmgr, dqmgr;
  logic [47:0] qnum, pqnum, dqnum;
  logic [31:0] skip;
  int errors = 0, cmp_count = 0, n_req[4], n_adv[4], n_done[4], n_rec[4], n_ret[4];
  logic [21:0] first_info [4];
  logic [13:0] dest_seen [4];
  logic [7:0] later_skip [4];
  initial forever #2.5 clk = ~clk;
  rxg_top #(.GAP(4)) i_dut (.CLK_SYS_I(clk), .ARST_N_I(arst_n), .CE_I(1'b1), .ADDRESS_I(addr),
    .READ_I(rd), .WRITE_I(wr), .WRITEDATA_I(wd), .BYTEENABLE_I(be), .READDATA_O(rdata),
    .WAITREQUEST_O(waitreq), .BLK_VALID_I(valid), .BLK_SOP_I(sop), .BLK_EOP_I(eop), .OVR_I(ovr_f),
    .OVR_KIND_I(kind), .OVR_QMGR_I(qmgr), .OVR_QNUM_I(qnum), .STARVE_I(starve), .ADV_O(adv),
    .BUF_REQ_O(breq), .BUF_FIRST_O(bfirst), .POOL_QMGR_O(pqmgr), .POOL_QNUM_O(pqnum), .SKIP_O(skip),
    .DONE_O(done), .DEST_QMGR_O(dqmgr), .DEST_QNUM_O(dqnum), .RECLAIM_O(recl), .RETRY_O(retry));
  rxg_far_model #(.CH(4)) i_far (.clk_i(clk), .rst_n_i(arst_n), .load_i(load), .len_i(len),
    .starve_cfg_i(stv), .ovr_cfg_i(ovr), .adv_i(adv), .buf_req_i(breq), .valid_o(valid), .sop_o(sop),
    .eop_o(eop), .ovr_o(ovr_f), .starve_o(starve), .kind_o(kind), .qmgr_o(qmgr), .qnum_o(qnum));
  // Pulse monitor, values taken mid-cycle where they are settled
  always @(negedge clk) begin
    for (int g = 0; g < 4; g++) begin
      if (breq[g] === 1'b1) begin
        n_req[g]++;
        if (bfirst[g] === 1'b1) first_info[g] = {pqmgr[2*g +: 2], pqnum[12*g +: 12], skip[8*g +: 8]};
        else later_skip[g] = skip[8*g +: 8];
      end
      if (adv[g] === 1'b1) n_adv[g]++;
      if (recl[g] === 1'b1) n_rec[g]++;
      if (retry[g] === 1'b1) n_ret[g]++;
      if (done[g] === 1'b1) begin
        n_done[g]++;
        dest_seen[g] = {dqmgr[2*g +: 2], dqnum[12*g +: 12]};
      end
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [6:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk);
    addr <= a;
    wr <= w;
    rd <= !w;
    wd <= {16'h0000, d};
    be <= 4'h3;
    do begin
      @(posedge clk);
      n++;
    end while (waitreq !== 1'b0 && n < 50);
    q = rdata;
    if (n >= 50) chk("bus answer", 32'h0, 32'h1);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  function automatic logic [6:0] ra(input int g, input logic [1:0] r);
    return {1'b0, 2'(g), r, 2'b00};
  endfunction
  task automatic run_pkt(input int g, input logic [3:0] l, input logic s, input logic o);
    n_req[g] = 0;
    n_adv[g] = 0;
    n_done[g] = 0;
    n_rec[g] = 0;
    n_ret[g] = 0;
    later_skip[g] = 8'h00;
    @(posedge clk);
    stv[g] <= s;
    ovr[g] <= o;
    len <= l;
    load[g] <= 1'b1;
    @(posedge clk);
    load[g] <= 1'b0;
    // Model shows the loaded block from the previous edge on
    @(posedge clk);
    for (int n = 0; n < 60 && valid[g] === 1'b1 && n_ret[g] == 0; n++) @(posedge clk);
    repeat (4) @(posedge clk);
  endtask
  task automatic t_regs();
    for (int g = 0; g < 4; g++) begin
      bus(1'b0, ra(g, REG_CTRL_CFG), 16'h0);
      chk("ctrl reset", q, 32'h0);
      bus(1'b0, ra(g, REG_QUEUE_CFG), 16'h0);
      chk("queue reset", q, {16'h0, QUEUE_CFG_RST});
      bus(1'b1, ra(g, REG_CTRL_CFG), 16'h3E00);
      bus(1'b0, ra(g, REG_CTRL_CFG), 16'h0);
      chk("ctrl reserved", q, 32'h0);
    end
    bus(1'b1, 7'h44, 16'h8000);
    bus(1'b0, 7'h44, 16'h0);
    chk("unmapped read", q, 32'h0);
  endtask
  task automatic t_flow();
    for (int g = 0; g < 4; g++) begin
      bus(1'b1, ra(g, REG_POOL_CFG), {2'b00, 2'(g + 1), 12'h200 + 12'(g)});
      bus(1'b1, ra(g, REG_QUEUE_CFG), {KIND_HOST, 2'(g), 12'h100 + 12'(g)});
      bus(1'b1, ra(g, REG_CTRL_CFG), 16'h0000);
      bus(1'b1, ra(g, REG_CTRL_CFG), {1'b1, 6'h0, 1'(g % 2), 8'h10 + 8'(g)});
      run_pkt(g, 4'h2, 1'b0, 1'b0);
      chk("done count", n_done[g], 1);
      chk("dest default", dest_seen[g], {2'(g), 12'h100 + 12'(g)});
      chk("first pool skip", first_info[g], {2'(g + 1), 12'h200 + 12'(g), 8'h10 + 8'(g)});
      chk("later skip", later_skip[g], 8'h00);
      chk("adv count", n_adv[g], 2);
    end
  endtask
  task automatic t_errors();
    run_pkt(1, 4'h1, 1'b0, 1'b1);
    chk("dest override", dest_seen[1], {2'h2, 12'hA01});
    bus(1'b1, ra(2, REG_QUEUE_CFG), {2'h2, 2'h0, 12'h005});
    run_pkt(2, 4'h1, 1'b0, 1'b0);
    chk("bad kind drop", {n_rec[2][7:0], n_done[2][7:0]}, 16'h0100);
    run_pkt(0, 4'h3, 1'b1, 1'b0);
    chk("drop reclaim", {n_rec[0][7:0], n_done[0][7:0], n_adv[0][7:0]}, 24'h010003);
    run_pkt(1, 4'h1, 1'b1, 1'b0);
    chk("retry no pop", {n_ret[1][7:0], n_adv[1][7:0], n_rec[1][7:0]}, 24'h010000);
    stv[1] <= 1'b0;
    for (int n = 0; n < 60 && n_done[1] == 0; n++) @(posedge clk);
    chk("retry completes", n_done[1], 1);
  endtask
  task automatic t_tdown();
    bus(1'b1, ra(3, REG_CTRL_CFG), 16'hC000);
    for (int n = 0; n < 20; n++) begin
      bus(1'b0, ra(3, REG_CTRL_CFG), 16'h0);
      if (q[15] === 1'b0) break;
    end
    chk("teardown flags", q[15:14], 2'b01);
    bus(1'b1, ra(3, REG_CTRL_CFG), 16'h0000);
    bus(1'b0, ra(3, REG_CTRL_CFG), 16'h0);
    chk("flag cleared", q, 32'h0);
    run_pkt(3, 4'h1, 1'b0, 1'b0);
    chk("disabled ignores", n_req[3], 0);
  endtask
  task automatic conclude();
    $display("Comparisons %0d, errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Whole run needs a few hundred cycles
  initial begin
    #100us;
    errors++;
    conclude();
  end
  initial begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_regs();
    t_flow();
    t_errors();
    t_tdown();
    conclude();
  end
endmodule
